// >>> dac_autopd_ctl.sv
// dac auto power-down, input pin readback and software/power-on reset control
`timescale 1ns/100ps
module dac_autopd_ctl (
  // clock and power-on reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register access from the host control port
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // port mode selection from the host control port
  input  wire logic       spiSelect,
  output logic            spiModeOn,
  // video timing and cable sense
  input  wire logic       frameStart,
  input  wire logic       cableSense1,
  input  wire logic       cableSense2,
  // input pins for readback
  input  wire logic       primary_pixel_clock_in,
  input  wire logic [9:0] pixS,
  input  wire logic [9:0] pixY,
  input  wire logic [9:0] pixC,
  input  wire logic [4:0] ctrlPins,
  input  wire logic       subcarrier_lock_pin,
  // dac power enables
  output logic      [2:0] dacPowerOn
);
  logic [dac_ctl_pkg::PIN_W-1:0] pinSync;
  logic [9:0] syncS;
  logic [9:0] syncY;
  logic [9:0] syncC;
  logic [4:0] syncCtrl;
  logic       syncLock;
  logic       syncPclk;
  logic       cable1;
  logic       cable2;

  // every readback and cable sense pin passes two flops before any logic reads it
  pin_sync #(.WIDTH(dac_ctl_pkg::PIN_W)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   ({cableSense2, cableSense1, primary_pixel_clock_in, subcarrier_lock_pin, ctrlPins, pixC, pixY, pixS}),
    .pinOut  (pinSync)
  );
  assign {cable2, cable1, syncPclk, syncLock, syncCtrl, syncC, syncY, syncS} = pinSync;

  // register state
  logic [2:0]  dacPower_r,   dacPower_nxt;
  logic [1:0]  cableStat_r,  cableStat_nxt;
  logic        detectEn_r,   detectEn_nxt;
  logic        autoPdEn_r,   autoPdEn_nxt;
  logic        component_r,  component_nxt;
  logic [2:0]  pdMask_r,     pdMask_nxt;
  logic [35:0] rbLatch_r,    rbLatch_nxt;
  logic        pclkPrev_r,   pclkPrev_nxt;
  logic [7:0]  rdData_r,     rdData_nxt;
  logic        spiMode_r,    spiMode_nxt;
  logic [2:0]  dacOn_r,      dacOn_nxt;
  logic        swReset;
  logic        autoActive;
  logic        mon1;
  logic        mon2;
  logic [2:0]  frameMask;

  assign swReset    = regWrEn && (regAddr == dac_ctl_pkg::SW_RESET_OFF)
                      && regWrData[dac_ctl_pkg::SW_RESET_BIT];
  assign autoActive = autoPdEn_r && detectEn_r;
  // a dac must be powered to be monitored
  assign mon1 = dacPower_r[0];
  assign mon2 = dacPower_r[1] && !component_r;

  // per-frame mask from sensed connection (sense high = cable attached)
  always_comb begin
    frameMask = dac_ctl_pkg::PD_NONE;
    if (component_r) begin
      if (mon1 && !cable1) frameMask = dac_ctl_pkg::PD_ALL;
    end else begin
      if (mon1 && !cable1) frameMask = frameMask | dac_ctl_pkg::PD_DAC1;
      if (mon2 && !cable2) frameMask = frameMask | dac_ctl_pkg::PD_DAC23;
    end
  end

  always_comb begin
    dacPower_nxt  = dacPower_r;
    cableStat_nxt = cableStat_r;
    detectEn_nxt  = detectEn_r;
    autoPdEn_nxt  = autoPdEn_r;
    component_nxt = component_r;
    pdMask_nxt    = pdMask_r;
    // cable status once per frame
    if (frameStart && detectEn_r) begin
      if (mon1) cableStat_nxt[dac_ctl_pkg::CABLE1_STAT_BIT] = !cable1;
      if (mon2) cableStat_nxt[dac_ctl_pkg::CABLE2_STAT_BIT] = !cable2;
    end
    // mask clears at once while auto is off, else moves only at a frame start, held through the frame
    if (!autoActive) begin
      pdMask_nxt = dac_ctl_pkg::PD_NONE;
    end else if (frameStart) begin
      pdMask_nxt = frameMask;
    end
    if (regWrEn) begin
      unique case (regAddr)
        dac_ctl_pkg::DAC_POWER_OFF: dacPower_nxt = regWrData[2:0];
        dac_ctl_pkg::CABLE_PD_OFF: begin
          detectEn_nxt = regWrData[dac_ctl_pkg::DETECT_EN_BIT];
          autoPdEn_nxt = regWrData[dac_ctl_pkg::AUTO_PD_EN_BIT];
        end
        dac_ctl_pkg::OUT_CONFIG_OFF: component_nxt = regWrData[dac_ctl_pkg::COMPONENT_BIT];
        default: ;
      endcase
    end
    // software reset returns all registers except the port mode to defaults
    if (swReset) begin
      dacPower_nxt  = dac_ctl_pkg::DAC_POWER_RST;
      cableStat_nxt = dac_ctl_pkg::CABLE_STAT_RST;
      detectEn_nxt  = dac_ctl_pkg::DETECT_EN_RST;
      autoPdEn_nxt  = dac_ctl_pkg::AUTO_PD_EN_RST;
      component_nxt = dac_ctl_pkg::COMPONENT_RST;
      pdMask_nxt    = dac_ctl_pkg::PD_NONE;
    end
  end

  // readback latch on rising edge of the pixel clock
  // latch goes stale while the pixel clock is stopped
  always_comb begin
    pclkPrev_nxt = syncPclk;
    rbLatch_nxt  = rbLatch_r;
    if (syncPclk && !pclkPrev_r) begin
      rbLatch_nxt = {syncLock, syncCtrl, syncC, syncY, syncS};
    end
    if (swReset) rbLatch_nxt = '0;
  end

  // register read mux, one cycle latency
  always_comb begin
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      unique case (regAddr)
        dac_ctl_pkg::DAC_POWER_OFF:  rdData_nxt = {5'h00, dacPower_r};
        dac_ctl_pkg::CABLE_PD_OFF:   rdData_nxt = {3'h0, autoPdEn_r, 1'b0, detectEn_r, cableStat_r};
        dac_ctl_pkg::OUT_CONFIG_OFF: rdData_nxt = {7'h00, component_r};
        dac_ctl_pkg::RB_S_HI_OFF:    rdData_nxt = rbLatch_r[9:2];
        dac_ctl_pkg::RB_Y_HI_OFF:    rdData_nxt = rbLatch_r[19:12];
        dac_ctl_pkg::RB_C_HI_OFF:    rdData_nxt = rbLatch_r[29:22];
        dac_ctl_pkg::RB_LOW_OFF:     rdData_nxt = {rbLatch_r[1:0], rbLatch_r[11:10], rbLatch_r[21:20], 2'h0};
        dac_ctl_pkg::RB_CTRL_OFF:    rdData_nxt = {2'h0, rbLatch_r[35:30]};
        dac_ctl_pkg::SW_RESET_OFF:   rdData_nxt = {7'h00, spiMode_r};
        default:                     rdData_nxt = 8'h00;
      endcase
    end
  end

  // port mode survives software reset
  always_comb begin
    spiMode_nxt = spiMode_r || spiSelect;
    dacOn_nxt   = dacPower_r & ~pdMask_r;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dacPower_r  <= dac_ctl_pkg::DAC_POWER_RST;
      cableStat_r <= dac_ctl_pkg::CABLE_STAT_RST;
      detectEn_r  <= dac_ctl_pkg::DETECT_EN_RST;
      autoPdEn_r  <= dac_ctl_pkg::AUTO_PD_EN_RST;
      component_r <= dac_ctl_pkg::COMPONENT_RST;
      pdMask_r    <= dac_ctl_pkg::PD_NONE;
      rbLatch_r   <= '0;
      pclkPrev_r  <= 1'b0;
      rdData_r    <= 8'h00;
      spiMode_r   <= 1'b0;
      dacOn_r     <= 3'h0;
    end else begin
      dacPower_r  <= dacPower_nxt;
      cableStat_r <= cableStat_nxt;
      detectEn_r  <= detectEn_nxt;
      autoPdEn_r  <= autoPdEn_nxt;
      component_r <= component_nxt;
      pdMask_r    <= pdMask_nxt;
      rbLatch_r   <= rbLatch_nxt;
      pclkPrev_r  <= pclkPrev_nxt;
      rdData_r    <= rdData_nxt;
      spiMode_r   <= spiMode_nxt;
      dacOn_r     <= dacOn_nxt;
    end
  end

  assign regRdData  = rdData_r;
  assign spiModeOn  = spiMode_r;
  assign dacPowerOn = dacOn_r;

  // checks
  // write-free cycles keep the next register values predictable
  logic       noWr;
  logic [7:0] rbSHi;
  assign noWr  = !regWrEn;
  assign rbSHi = rbLatch_r[9:2];

  a_autopd_enable: assert property (@(posedge ref_clk) disable iff (reset)
    regWrEn && regAddr == 8'h10 |=> autoPdEn_r == $past(regWrData[4]))
    else $error("auto power-down enable not taken from bit 4");
  a_needs_detect: assert property (@(posedge ref_clk) disable iff (reset)
    !detectEn_r |=> pdMask_r == 3'h0)
    else $error("auto power-down active without cable detection");
  a_comp_all_down: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && autoActive && noWr && component_r && dacPower_r[0] && !cable1 |=> pdMask_r == 3'h7)
    else $error("component mode dac1 open did not power all down");
  a_comp_dac2_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && autoActive && noWr && component_r && cable1 |=> pdMask_r == 3'h0 && $stable(cableStat_r[1]))
    else $error("component mode used dac2 state");
  a_composite_output_config_split: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && autoActive && noWr && !component_r && dacPower_r == 3'h7 && cable1 && !cable2
    |=> pdMask_r == 3'h6)
    else $error("composite dac2 open wrong mask");
  a_frame_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !frameStart && autoActive && noWr ##1 autoActive |-> $stable(pdMask_r))
    else $error("auto power changed inside a frame");
  a_status_bit: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && detectEn_r && dacPower_r[0] && noWr |=> cableStat_r[0] == !$past(cable1))
    else $error("dac1 cable status wrong");
  a_sw_defaults: assert property (@(posedge ref_clk) disable iff (reset)
    swReset |=> dacPower_r == 3'h7 && !autoPdEn_r && !detectEn_r ##1 dacPowerOn == 3'h7)
    else $error("software reset did not restore defaults");
  a_sw_selfclear: assert property (@(posedge ref_clk) disable iff (reset)
    regRdEn && regAddr == 8'h17 |=> !regRdData[1])
    else $error("software reset bit read back set");
  a_spi_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    spiModeOn |=> spiModeOn)
    else $error("port mode lost");
  a_power_out: assert property (@(posedge ref_clk) disable iff (reset)
    !autoActive && noWr ##1 noWr |=> dacPowerOn == dacPower_r)
    else $error("dac power differs from normal controls while auto off");

  // frame check per dac
  a_composite_output_config_dac1_only: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && autoActive && noWr && !component_r && dacPower_r[0] && !cable1
    && (!dacPower_r[1] || cable2) |=> pdMask_r == 3'h1)
    else $error("composite dac1 open wrong mask");
  a_cable_kept_on: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && autoActive && noWr && !component_r && cable1 |=> !pdMask_r[0])
    else $error("composite dac1 with cable powered down");
  a_open_held_down: assert property (@(posedge ref_clk) disable iff (reset)
    autoActive && pdMask_r[0] && !frameStart && noWr |=> pdMask_r[0])
    else $error("dac1 powered up before next frame");
  a_status_frame: assert property (@(posedge ref_clk) disable iff (reset)
    !frameStart && noWr |=> $stable(cableStat_r))
    else $error("cable status moved between frames");
  a_dac2_status: assert property (@(posedge ref_clk) disable iff (reset)
    frameStart && detectEn_r && dacPower_r[1] && !component_r && noWr |=> cableStat_r[1] == !$past(cable2))
    else $error("dac2 cable status wrong");
  a_dac_steady: assert property (@(posedge ref_clk) disable iff (reset)
    !frameStart && autoActive && noWr |=> ##1 $stable(dacPowerOn))
    else $error("dac power moved inside a frame");

  // readback and reset
  a_rb_capture: assert property (@(posedge ref_clk) disable iff (reset)
    syncPclk && !pclkPrev_r && noWr |=> rbLatch_r[9:0] == $past(syncS))
    else $error("pixel input levels not captured");
  a_rb_read: assert property (@(posedge ref_clk) disable iff (reset)
    regRdEn && regAddr == 8'h12 |=> regRdData == $past(rbSHi))
    else $error("readback register wrong");
  a_sw_take: assert property (@(posedge ref_clk) disable iff (reset)
    regWrEn && regAddr == 8'h17 && regWrData[1] |=> dacPower_r == 3'h7 && pdMask_r == 3'h0)
    else $error("software reset write ignored");
  a_por_state: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> dacPower_r == 3'h7 && cableStat_r == 2'h0 && !spiModeOn && regRdData == 8'h00)
    else $error("power-on reset state wrong");

  // main scenarios
  c_comp_down: cover property (@(posedge ref_clk) disable iff (reset)
    component_r && pdMask_r == 3'h7);
  c_composite_output_config_dac1: cover property (@(posedge ref_clk) disable iff (reset)
    !component_r && pdMask_r == 3'h1);
  c_sw_reset: cover property (@(posedge ref_clk) disable iff (reset) swReset && spiModeOn);
  c_composite_output_config_dac23: cover property (@(posedge ref_clk) disable iff (reset) !component_r && pdMask_r == 3'h6);
  c_readback: cover property (@(posedge ref_clk) disable iff (reset)
    regRdEn && regAddr == 8'h16 ##1 regRdData != 8'h00);
endmodule : dac_autopd_ctl

// >>> dac_autopd_ctl_test.sv
// self-checking bench for dac auto power-down, readback and reset control
`timescale 1ns/100ps
module dac_autopd_ctl_test;
  logic       ref_clk, reset, regWrEn, regRdEn, spiSelect, spiModeOn;
  logic       frameStart, cableSense1, cableSense2, pixClk, lockPin;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [9:0] pixS, pixY, pixC;
  logic [4:0] ctrlPins;
  logic [2:0] dacPowerOn;
  logic [7:0] rbAddr [5];
  logic [7:0] rbExp [5];
  int         errTotal, checksDone, cycles;

  video_src_model u_video_src_model (.ref_clk(ref_clk), .reset(reset), .frameStart(frameStart), .pixClk(pixClk));
  dac_autopd_ctl u_dac_autopd_ctl (.ref_clk(ref_clk), .reset(reset), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .spiSelect(spiSelect), .spiModeOn(spiModeOn),
    .frameStart(frameStart), .cableSense1(cableSense1), .cableSense2(cableSense2), .primary_pixel_clock_in(pixClk),
    .pixS(pixS), .pixY(pixY), .pixC(pixC), .ctrlPins(ctrlPins), .subcarrier_lock_pin(lockPin), .dacPowerOn(dacPowerOn));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
    chk(regRdData, exp);
  endtask : rd

  // waits for a frame boundary plus the power register delay
  task automatic waitFrame();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (frameStart !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 200) begin
      errTotal++;
      $display("ERROR t=%0t frame start missing got=%h exp=%h", $time, frameStart, 1'b1);
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : waitFrame

  task automatic sense(input logic s1, input logic s2);
    cableSense1 = s1;
    cableSense2 = s2;
  endtask : sense

  initial begin
    {errTotal, checksDone, cycles} = 0;
    {regWrEn, regRdEn, spiSelect, regAddr, regWrData} = '0;
    reset = 1'b1;
    sense(1'b0, 1'b0);
    pixS = 10'h2A5;
    pixY = 10'h15A;
    pixC = 10'h3C3;
    ctrlPins = 5'h15;
    lockPin = 1'b1;
    rbAddr = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    rbExp  = '{8'hA9, 8'h56, 8'hF0, 8'h6C, 8'h35};
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rd(dac_ctl_pkg::DAC_POWER_OFF, 8'h07);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h00);
    rd(8'h20, 8'h00);
    wr(dac_ctl_pkg::CABLE_PD_OFF, 8'h10);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h07);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h10);
    sense(1'b0, 1'b1);
    wr(dac_ctl_pkg::CABLE_PD_OFF, 8'h14);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h06);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h15);
    sense(1'b1, 1'b0);
    repeat (10) @(posedge ref_clk);
    #1;
    chk({5'h00, dacPowerOn}, 8'h06);
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h01);
    repeat (30) @(posedge ref_clk);
    #1;
    chk({5'h00, dacPowerOn}, 8'h01);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h16);
    wr(dac_ctl_pkg::OUT_CONFIG_OFF, 8'h01);
    sense(1'b0, 1'b1);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h00);
    sense(1'b1, 1'b0);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h07);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h16);
    sense(1'b0, 1'b0);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h00);
    wr(dac_ctl_pkg::CABLE_PD_OFF, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({5'h00, dacPowerOn}, 8'h07);
    for (int i = 0; i < 5; i++) begin
      rd(rbAddr[i], rbExp[i]);
    end
    @(posedge ref_clk);
    #1;
    spiSelect = 1'b1;
    @(posedge ref_clk);
    #1;
    spiSelect = 1'b0;
    wr(dac_ctl_pkg::DAC_POWER_OFF, 8'h03);
    wr(dac_ctl_pkg::OUT_CONFIG_OFF, 8'h01);
    wr(dac_ctl_pkg::SW_RESET_OFF, 8'h02);
    rd(dac_ctl_pkg::SW_RESET_OFF, 8'h01);
    rd(dac_ctl_pkg::DAC_POWER_OFF, 8'h07);
    rd(dac_ctl_pkg::OUT_CONFIG_OFF, 8'h00);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h00);
    chk({7'h00, spiModeOn}, 8'h01);
    @(posedge ref_clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk({7'h00, spiModeOn}, 8'h00);
    sense(1'b0, 1'b1);
    wr(dac_ctl_pkg::DAC_POWER_OFF, 8'h06);
    wr(dac_ctl_pkg::CABLE_PD_OFF, 8'h14);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h06);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h14);
    wr(dac_ctl_pkg::DAC_POWER_OFF, 8'h07);
    waitFrame();
    waitFrame();
    chk({5'h00, dacPowerOn}, 8'h06);
    rd(dac_ctl_pkg::CABLE_PD_OFF, 8'h15);
    tally_and_finish();
  end
endmodule : dac_autopd_ctl_test

// >>> dac_ctl_pkg.sv
// constants for dac auto power-down, pin readback and reset control
package dac_ctl_pkg;
  // register offsets
  localparam logic [7:0] DAC_POWER_OFF     = 8'h00;
  localparam logic [7:0] CABLE_PD_OFF      = 8'h10;
  localparam logic [7:0] OUT_CONFIG_OFF    = 8'h11;
  localparam logic [7:0] RB_S_HI_OFF       = 8'h12;
  localparam logic [7:0] RB_Y_HI_OFF       = 8'h13;
  localparam logic [7:0] RB_C_HI_OFF       = 8'h14;
  localparam logic [7:0] RB_LOW_OFF        = 8'h15;
  localparam logic [7:0] RB_CTRL_OFF       = 8'h16;
  localparam logic [7:0] SW_RESET_OFF      = 8'h17;
  // field positions
  localparam int CABLE1_STAT_BIT  = 0;
  localparam int CABLE2_STAT_BIT  = 1;
  localparam int DETECT_EN_BIT    = 2;
  localparam int AUTO_PD_EN_BIT   = 4;
  localparam int COMPONENT_BIT    = 0;
  localparam int SW_RESET_BIT     = 1;
  // reset values
  localparam logic [2:0] DAC_POWER_RST   = 3'h7;
  localparam logic [1:0] CABLE_STAT_RST  = 2'h0;
  localparam logic       DETECT_EN_RST   = 1'b0;
  localparam logic       AUTO_PD_EN_RST  = 1'b0;
  localparam logic       COMPONENT_RST   = 1'b0;
  // power-down masks (bit n = dac n+1)
  localparam logic [2:0] PD_NONE         = 3'h0;
  localparam logic [2:0] PD_DAC1         = 3'h1;
  localparam logic [2:0] PD_DAC23        = 3'h6;
  localparam logic [2:0] PD_ALL          = 3'h7;
  // synchronised pin vector width: 30 pixel, 5 control, lock pin, pixel clock, 2 sense
  localparam int PIN_W = 39;
endpackage : dac_ctl_pkg

// >>> pin_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
    end
  end

  assign pinOut = stage2_r;
endmodule : pin_sync

// >>> video_src_model.sv
// video-side model: frame pulses and a running pixel clock
`timescale 1ns/100ps
module video_src_model #(
  parameter int FRAME_LEN = 64
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // video side
  output logic      frameStart,
  output logic      pixClk
);
  int cnt;
  initial begin
    frameStart = 1'b0;
    pixClk     = 1'b0;
    cnt        = 0;
  end
  // pixel clock kept running so readback latches stay fresh
  always @(posedge ref_clk) begin
    cnt        <= #1 (reset || cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
    frameStart <= #1 !reset && cnt == FRAME_LEN - 1;
    if (cnt[0]) pixClk <= #1 ~pixClk;
  end
endmodule : video_src_model
